/* src/jfa_port.sv */
// jtag-side flash access port: control, address pointer and data registers
// Summary of operation
// - scratch select set routes accesses other than mass erase to 128-byte scratchpad, else main sector
// - write action 000: data write only updates the held byte
// - write action 001: program byte at pointer, then pointer plus one; a locked target fails and keeps the pointer
// - write action 010 with key 0xa5: erase pointer page to 0xff, pointer kept
// - erase with pointer 0x7bfe or 0x7bff erases all user space, reserved kept
// - read action 0000: read returns held data, no flash activity
// - read action 0001: every read fetches byte at pointer when idle
// - read action 0010: fetch only when idle and previous result consumed
// - data byte sits in data register bits 9 to 2
module jfa_port
    import jfa_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ctl_wr,
    input  wire logic [7:0]  ctl_wdata,
    output wire logic [7:0]  ctl_rdata,
    input  wire logic        adr_wr,
    input  wire logic [15:0] adr_wdata,
    output wire logic [15:0] adr_rdata,
    input  wire logic        dat_wr,
    input  wire logic [7:0]  dat_wdata,
    input  wire logic        dat_rd,
    output wire logic [9:0]  dat_rdata
);
    jfa_op_if opb ();

    typedef enum logic [1:0] {
        JFA_IDLE = 2'b00,
        JFA_WAIT = 2'b01
    } jfa_state_type;

    typedef struct packed {
        jfa_state_type state;
        logic [7:0]    ctl;
        logic [15:0]   adr;
        logic [7:0]    data;
        logic          fail;
        logic          unread;
        logic          incr;
        jfa_op_type    op;
        logic          start;
    } jfa_port_type;

    jfa_port_type st_r;
    jfa_port_type st_nxt;

    logic       busy;
    logic [2:0] wr_act;
    logic [3:0] rd_act;

    assign busy   = (st_r.state != JFA_IDLE) || st_r.start;
    assign wr_act = st_r.ctl[CTL_WR_HI:CTL_WR_LO];
    assign rd_act = st_r.ctl[CTL_RD_HI:CTL_RD_LO];

    // register updates and operation launch; writes take priority over reads
    always_comb begin
        st_nxt       = st_r;
        st_nxt.start = 1'b0;
        if (ctl_wr)
            st_nxt.ctl = ctl_wdata;
        if (adr_wr && !busy)
            st_nxt.adr = adr_wdata;
        if (dat_wr) begin
            if (!busy) begin
                st_nxt.data = dat_wdata;
                if (wr_act == WR_PROGRAM) begin
                    st_nxt.op    = JFA_OP_PROG;
                    st_nxt.start = 1'b1;
                    st_nxt.incr  = 1'b1;
                end else if (wr_act == WR_ERASE && dat_wdata == ERASE_KEY) begin
                    st_nxt.incr  = 1'b0;
                    st_nxt.start = 1'b1;
                    if (st_r.adr == MASS_ERASE_LO || st_r.adr == MASS_ERASE_HI)
                        st_nxt.op = JFA_OP_MASS;
                    else
                        st_nxt.op = JFA_OP_PAGE;
                end
            end
        end else if (dat_rd && !busy) begin
            // reading out the held byte consumes any fetched result
            st_nxt.unread = 1'b0;
            if (rd_act == RD_BLOCK || (rd_act == RD_SINGLE && !st_r.unread)) begin
                st_nxt.op    = JFA_OP_READ;
                st_nxt.start = 1'b1;
                st_nxt.incr  = 1'b0;
            end
        end
        if (st_nxt.start)
            st_nxt.fail = 1'b0;
        case (st_r.state)
            JFA_IDLE: begin
                if (st_r.start)
                    st_nxt.state = JFA_WAIT;
            end
            JFA_WAIT: begin
                if (opb.done) begin
                    st_nxt.state = JFA_IDLE;
                    st_nxt.fail  = opb.fail;
                    if (st_r.op == JFA_OP_READ && !opb.fail) begin
                        st_nxt.data   = opb.rdata;
                        st_nxt.unread = 1'b1;
                    end
                    if (st_r.incr && !opb.fail)
                        st_nxt.adr = st_r.adr + 16'h0001;
                end
            end
            default: st_nxt.state = JFA_IDLE;
        endcase
        if (sys_rst) begin
            st_nxt       = '0;
            st_nxt.ctl   = CTL_RESET;
            st_nxt.adr   = ADR_RESET;
            st_nxt.state = JFA_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // engine command; sector chosen by the scratch select bit
    assign opb.op      = st_r.op;
    assign opb.start   = st_r.start;
    assign opb.scratch = st_r.ctl[CTL_SCRATCH_BIT];
    assign opb.addr    = st_r.adr;
    assign opb.wdata   = st_r.data;

    jfa_array u_array (
        .clk     (clk),
        .sys_rst (sys_rst),
        .bus     (opb)
    );

    assign ctl_rdata = st_r.ctl;
    assign adr_rdata = st_r.adr;
    // busy is combinational so a launch is visible the cycle after the access
    assign dat_rdata = {st_r.data, st_r.fail, busy};
endmodule // jfa_port

/* common/jfa_pkg.sv */
// package for the jtag flash access port: register layout, modes, timing
package jfa_pkg;
    // control register fields
    localparam int          CTL_SCRATCH_BIT   = 7;
    localparam int          CTL_WR_HI         = 6;
    localparam int          CTL_WR_LO         = 4;
    localparam int          CTL_RD_HI         = 3;
    localparam int          CTL_RD_LO         = 0;
    localparam logic [7:0]  CTL_RESET         = 8'h00;
    // data register fields
    localparam int          DAT_BYTE_HI       = 9;
    localparam int          DAT_BYTE_LO       = 2;
    localparam int          DAT_FAIL_BIT      = 1;
    localparam int          DAT_BUSY_BIT      = 0;
    localparam logic [9:0]  DAT_RESET         = 10'h000;
    localparam logic [15:0] ADR_RESET         = 16'h0000;
    // write and read actions
    localparam logic [2:0]  WR_HOLD           = 3'h0;
    localparam logic [2:0]  WR_PROGRAM        = 3'h1;
    localparam logic [2:0]  WR_ERASE          = 3'h2;
    localparam logic [3:0]  RD_HOLD           = 4'h0;
    localparam logic [3:0]  RD_BLOCK          = 4'h1;
    localparam logic [3:0]  RD_SINGLE         = 4'h2;
    // erase key, erased value, address map
    localparam logic [7:0]  ERASE_KEY         = 8'ha5;
    localparam logic [7:0]  ERASED_BYTE       = 8'hff;
    localparam logic [15:0] MASS_ERASE_LO     = 16'h7bfe;
    localparam logic [15:0] MASS_ERASE_HI     = 16'h7bff;
    localparam logic [15:0] RESERVED_BASE     = 16'h7c00;
    localparam logic [15:0] RESERVED_LAST     = 16'h7fff;
    localparam int          MAIN_DEPTH        = 32768;
    localparam int          SCRATCH_DEPTH     = 128;
    localparam int          PAGE_BITS         = 10;
    // flash op duration
    localparam int          CLK_MHZ           = 250;
    localparam int          OP_TIME_NS        = 40;
    localparam int          OP_CYCLES         = (OP_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  OP_COUNT          = 8'(OP_CYCLES);
    // engine commands
    typedef enum logic [2:0] {
        JFA_OP_NONE  = 3'h0,
        JFA_OP_READ  = 3'h1,
        JFA_OP_PROG  = 3'h2,
        JFA_OP_PAGE  = 3'h3,
        JFA_OP_MASS  = 3'h4
    } jfa_op_type;
endpackage : jfa_pkg

/* common/jfa_op_if.sv */
// command and result signals between the access port and the flash array
interface jfa_op_if;
    import jfa_pkg::*;
    jfa_op_type  op;
    logic        start;
    logic        scratch;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        done;
    logic        fail;
    logic [7:0]  rdata;
    modport ctl (output op, start, scratch, addr, wdata, input done, fail, rdata);
    modport mem (input op, start, scratch, addr, wdata, output done, fail, rdata);
endinterface : jfa_op_if

/* src/jfa_array.sv */
// flash array model with main and scratchpad sectors and a timed engine
module jfa_array
    import jfa_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    jfa_op_if.mem     bus
);
    logic [7:0] main_mem    [MAIN_DEPTH];
    logic [7:0] scratch_mem [SCRATCH_DEPTH];

    typedef struct packed {
        logic [7:0]  cnt;
        logic        run;
        jfa_op_type  op;
        logic        scratch;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        done;
        logic        fail;
        logic [7:0]  rdata;
    } jfa_arr_type;

    jfa_arr_type st_r;
    jfa_arr_type st_nxt;

    // locked when a main-sector address falls in the reserved region
    function automatic logic jfa_locked(input logic sc, input logic [15:0] a);
        return !sc && (a >= RESERVED_BASE) && (a <= RESERVED_LAST);
    endfunction

    // engine sequencing: latch, count, finish
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (bus.start && !st_r.run) begin
            st_nxt.run     = 1'b1;
            st_nxt.cnt     = OP_COUNT;
            st_nxt.op      = bus.op;
            st_nxt.scratch = bus.scratch;
            st_nxt.addr    = bus.addr;
            st_nxt.wdata   = bus.wdata;
        end else if (st_r.run) begin
            st_nxt.cnt = st_r.cnt - 8'h01;
            if (st_r.cnt == 8'h01) begin
                st_nxt.run  = 1'b0;
                st_nxt.done = 1'b1;
                st_nxt.fail = (st_r.op != JFA_OP_MASS) && jfa_locked(st_r.scratch, st_r.addr);
                if (st_r.op == JFA_OP_READ)
                    st_nxt.rdata = st_r.scratch ? scratch_mem[st_r.addr[6:0]] : main_mem[st_r.addr[14:0]];
            end
        end
        if (sys_rst) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // array contents change only when an op completes; memories carry no reset
    always_ff @(posedge clk) begin
        if (st_r.run && st_r.cnt == 8'h01 && !sys_rst) begin
            if (st_r.op == JFA_OP_PROG && !jfa_locked(st_r.scratch, st_r.addr)) begin
                if (st_r.scratch)
                    scratch_mem[st_r.addr[6:0]] <= st_r.wdata;
                else
                    main_mem[st_r.addr[14:0]] <= st_r.wdata;
            end else if (st_r.op == JFA_OP_PAGE && !jfa_locked(st_r.scratch, st_r.addr)) begin
                if (st_r.scratch) begin
                    for (int i = 0; i < SCRATCH_DEPTH; i++)
                        scratch_mem[i] <= ERASED_BYTE;
                end else begin
                    for (int i = 0; i < MAIN_DEPTH; i++)
                        if ((i >> PAGE_BITS) == int'(st_r.addr[14:PAGE_BITS]))
                            main_mem[i] <= ERASED_BYTE;
                end
            end else if (st_r.op == JFA_OP_MASS) begin
                for (int i = 0; i < MAIN_DEPTH; i++)
                    if (i < int'(RESERVED_BASE))
                        main_mem[i] <= ERASED_BYTE;
            end
        end
    end

    assign bus.done  = st_r.done;
    assign bus.fail  = st_r.fail;
    assign bus.rdata = st_r.rdata;
endmodule // jfa_array

/* tb/jfa_port_checker.sv */
// assertion checker bound to the jtag flash access port
module jfa_port_checker
    import jfa_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        ctl_wr,
    input wire logic [7:0]  ctl_wdata,
    input wire logic [7:0]  ctl_rdata,
    input wire logic        adr_wr,
    input wire logic [15:0] adr_wdata,
    input wire logic [15:0] adr_rdata,
    input wire logic        dat_wr,
    input wire logic [7:0]  dat_wdata,
    input wire logic        dat_rd,
    input wire logic [9:0]  dat_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // decoded view; locked targets are left out although they still run the full count and then fail
    wire logic       busy = dat_rdata[DAT_BUSY_BIT];
    wire logic [2:0] wact = ctl_rdata[CTL_WR_HI:CTL_WR_LO];
    wire logic [3:0] ract = ctl_rdata[CTL_RD_HI:CTL_RD_LO];
    wire logic       wgo  = dat_wr && !busy;
    wire logic       rgo  = dat_rd && !dat_wr && !busy;
    wire logic       free = adr_rdata < RESERVED_BASE;
    sequence op_s;
        busy ##[1:20] !busy;
    endsequence
    hold_write_a: assert property (wgo && wact == WR_HOLD |=> !busy && dat_rdata[9:2] == $past(dat_wdata))
        else $error("hold write misbehaved");
    prog_start_a: assert property (wgo && wact == WR_PROGRAM && free |=> op_s)
        else $error("program did not run");
    ptr_step_a: assert property ($changed(adr_rdata) && !$past(adr_wr) |-> adr_rdata == $past(adr_rdata) + 16'h0001)
        else $error("pointer moved by other than one");
    erase_start_a: assert property (wgo && wact == WR_ERASE && dat_wdata == ERASE_KEY && free |=> op_s)
        else $error("keyed erase did not run");
    hold_read_a: assert property (rgo && ract == RD_HOLD |=> !busy && $stable(dat_rdata))
        else $error("hold read changed the data port");
    block_read_a: assert property (rgo && ract == RD_BLOCK && free |=> op_s)
        else $error("block read did not fetch");
    busy_cause_a: assert property ($rose(busy) |-> $past(dat_wr || dat_rd))
        else $error("busy rose without an access");
    busy_drop_a: assert property (busy && (dat_wr || dat_rd || adr_wr) |-> ##[0:16] !busy)
        else $error("access while busy extended the operation");
endmodule // jfa_port_checker

bind jfa_port jfa_port_checker u_chk (.clk, .sys_rst, .ctl_wr, .ctl_wdata, .ctl_rdata, .adr_wr, .adr_wdata,
    .adr_rdata, .dat_wr, .dat_wdata, .dat_rd, .dat_rdata);

/* tb/jfa_host.sv */
// jtag host model: register strobes and busy polling
module jfa_host
    import jfa_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [9:0] dat_rdata,
    output logic            ctl_wr,
    output logic [7:0]      ctl_wdata,
    output logic            adr_wr,
    output logic [15:0]     adr_wdata,
    output logic            dat_wr,
    output logic [7:0]      dat_wdata,
    output logic            dat_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {ctl_wr, adr_wr, dat_wr, dat_rd} = 4'h0;
        {ctl_wdata, adr_wdata, dat_wdata} = 32'h0;
    end
    // one-cycle strobe; data lines flip afterwards so a stale value never looks valid
    task automatic acc(input int k, input logic [15:0] d);
        @(posedge clk);
        case (k)
            0: {ctl_wr, ctl_wdata} <= {1'b1, d[7:0]};
            1: {adr_wr, adr_wdata} <= {1'b1, d};
            2: {dat_wr, dat_wdata} <= {1'b1, d[7:0]};
            default: dat_rd <= 1'b1;
        endcase
        @(posedge clk);
        {ctl_wr, adr_wr, dat_wr, dat_rd} <= 4'h0;
        {ctl_wdata, adr_wdata, dat_wdata} <= ~{ctl_wdata, adr_wdata, dat_wdata};
    endtask
    // bounded poll of busy before the next starting access
    task automatic idle();
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (dat_rdata[DAT_BUSY_BIT] !== 1'b1)
                break;
        end
    endtask
endmodule // jfa_host

/* tb/tb_jtag_flash_access_port.sv */
// testbench for the jtag flash access port driven by the host model
module tb_jtag_flash_access_port
    import jfa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]  c;
        logic [15:0] a;
        logic [7:0]  d;
        logic        w;
        logic [9:0]  x;
        logic [9:0]  m;
        logic [15:0] xa;
    } jfa_row_type;
    logic        clk;
    logic        sys_rst;
    logic        ctl_wr, adr_wr, dat_wr, dat_rd;
    logic [7:0]  ctl_wdata, ctl_rdata, dat_wdata;
    logic [15:0] adr_wdata, adr_rdata;
    logic [9:0]  dat_rdata;
    int          errors, tests_run;
    // control, pointer, byte, write or read, expected data port under mask, pointer
    jfa_row_type rows [15] = '{
        '{8'h10, 16'h0010, 8'h3c, 1'b1, 10'h0f0, 10'h3ff, 16'h0011},
        '{8'h10, 16'h0400, 8'h77, 1'b1, 10'h1dc, 10'h3ff, 16'h0401},
        '{8'h90, 16'h0010, 8'h5a, 1'b1, 10'h168, 10'h3ff, 16'h0011},
        '{8'h01, 16'h0010, 8'h00, 1'b0, 10'h0f0, 10'h3ff, 16'h0010},
        '{8'h81, 16'h0010, 8'h00, 1'b0, 10'h168, 10'h3ff, 16'h0010},
        '{8'h20, 16'h0010, 8'ha5, 1'b1, 10'h000, 10'h001, 16'h0010},
        '{8'h01, 16'h0010, 8'h00, 1'b0, 10'h3fc, 10'h3ff, 16'h0010},
        '{8'h20, 16'h0400, 8'h5b, 1'b1, 10'h16c, 10'h3ff, 16'h0400},
        '{8'h01, 16'h0400, 8'h00, 1'b0, 10'h1dc, 10'h3ff, 16'h0400},
        '{8'h81, 16'h0010, 8'h00, 1'b0, 10'h168, 10'h3ff, 16'h0010},
        '{8'h10, 16'h7c00, 8'h11, 1'b1, 10'h002, 10'h003, 16'h7c00},
        '{8'h20, 16'h7bfe, 8'ha5, 1'b1, 10'h000, 10'h001, 16'h7bfe},
        '{8'h01, 16'h0400, 8'h00, 1'b0, 10'h3fc, 10'h3ff, 16'h0400},
        '{8'h00, 16'h0400, 8'h42, 1'b1, 10'h108, 10'h3ff, 16'h0400},
        '{8'h00, 16'h0400, 8'h00, 1'b0, 10'h108, 10'h3ff, 16'h0400}
    };
    jfa_port u_dut (.clk, .sys_rst, .ctl_wr, .ctl_wdata, .ctl_rdata, .adr_wr, .adr_wdata, .adr_rdata,
        .dat_wr, .dat_wdata, .dat_rd, .dat_rdata);
    jfa_host u_host (.clk, .dat_rdata, .ctl_wr, .ctl_wdata, .adr_wr, .adr_wdata, .dat_wr, .dat_wdata, .dat_rd);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // reset held for 20 cycles, then every register must read its default
    task automatic rst();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk(ctl_rdata, CTL_RESET);
        chk(adr_rdata, ADR_RESET);
        chk(dat_rdata, DAT_RESET);
    endtask
    // watchdog: all tests need well under 1000 cycles
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        conclude();
    end
    initial begin
        errors = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        rst();
        foreach (rows[i]) begin
            u_host.acc(0, {8'h00, rows[i].c});
            u_host.acc(1, rows[i].a);
            u_host.acc(rows[i].w ? 2 : 3, {8'h00, rows[i].d});
            u_host.idle();
            chk(ctl_rdata, rows[i].c);
            chk(dat_rdata & rows[i].m, rows[i].x);
            chk(adr_rdata, rows[i].xa);
        end
        // a write and a pointer load made while busy must both be dropped
        u_host.acc(0, 16'h0010);
        u_host.acc(1, 16'h0020);
        u_host.acc(2, 16'h0066);
        u_host.acc(2, 16'h0099);
        u_host.acc(1, 16'h1234);
        u_host.idle();
        chk(dat_rdata, 10'h198);
        chk(adr_rdata, 16'h0021);
        rst();
        // single-fetch mode: reading an unread result only consumes it
        u_host.acc(0, 16'h0002);
        u_host.acc(1, 16'h0020);
        u_host.acc(3, 16'h0000);
        #1;
        chk(dat_rdata[DAT_BUSY_BIT], 1'b1);
        u_host.idle();
        u_host.acc(3, 16'h0000);
        #1;
        chk(dat_rdata[DAT_BUSY_BIT], 1'b0);
        u_host.acc(3, 16'h0000);
        #1;
        chk(dat_rdata[DAT_BUSY_BIT], 1'b1);
        u_host.idle();
        conclude();
    end
endmodule // tb_jtag_flash_access_port
